// ===== rme_exec.sv
// Contract
// (RULE_01) Opcodes E7, E6, E4 select remainder of byte, halfword, word.
// (RULE_02) Remainder writes dividend operand modulo divisor operand to destination.
// (RULE_03) Remainder flags: N if negative, Z if zero, C cleared, V on overflow.
// (RULE_04) Zero divisor raises the integer zero-divide exception.
// (RULE_05) Remainder truncated to destination size raises integer overflow exception.
// (RULE_06) Literal or immediate destination raises illegal operand exception.
// (RULE_07) Opcodes 87, 86, 84 copy source to destination in three sizes.
// (RULE_08) Copy flags: N is result MSB, Z if zero, C cleared, V if truncated.
// (RULE_09) Expanded destination type converts the value; source type picks extension.
// (RULE_10) Signed byte or half sign-extends; byte or unsigned half zero-extends.
// (RULE_11) Word copy to or from status word leaves flags unchanged.
// (RULE_12) Remainder uses truncating signed division; remainder follows dividend sign.
`default_nettype none
module rme_exec (
  // Clock, reset, enable
  input  wire logic        mclk_i,
  input  wire logic        rst_b_i,
  input  wire logic        ce_i,
  // Avalon-MM slave
  input  wire logic [5:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  // Execution state
  output logic             busy_o,
  output logic             done_o
);
  import rme_pkg::*;

  typedef struct packed {
    rme_state_t  st;
    logic        ack;
    logic [31:0] rdata;
    logic [7:0]  opcode;
    logic [2:0]  src_type;
    logic [2:0]  dst_type;
    logic [2:0]  mode;
    logic [31:0] divisor_operand;
    logic [31:0] dividend_operand;
    logic [31:0] result;
    logic [3:0]  flags;
    logic [3:0]  exc;
    logic        done;
    logic        div_start;
    logic [31:0] mag_a;
    logic [31:0] mag_b;
    logic        neg;
    logic [1:0]  dsz;
    logic        dsg;
  } rme_exec_t;

  rme_exec_t   r;
  rme_exec_t   next_r;

  rme_div_if   div_bus ();

  // Decode and operand view
  logic        req;
  logic        wr_now;
  logic        start;
  logic [5:0]  addr;
  logic        is_rem;
  logic        is_copy;
  logic        is_copy_word;
  logic        opc_ok;
  logic [1:0]  opsz;
  logic [1:0]  ssz;
  logic        ssg;
  logic [1:0]  cur_dsz;
  logic        cur_dsg;
  logic [32:0] src_v;
  logic [32:0] a_v;
  logic [32:0] b_v;
  logic [32:0] rem_v;
  logic [32:0] cv;
  logic [1:0]  fsz;
  logic        fsg;
  logic [31:0] fin_res;
  logic        fin_fit;
  logic        fin_n;
  logic        fin_z;
  logic [31:0] rd_mux;

  // Value of the given size, extended as signed or unsigned
  function automatic logic [32:0] ext(input logic [31:0] v, input logic [1:0] sz,
                                      input logic sg);
    case (sz)
      SZ_BYTE: ext = sg ? {{25{v[7]}}, v[7:0]} : {25'h0000000, v[7:0]};
      SZ_HALF: ext = sg ? {{17{v[15]}}, v[15:0]} : {17'h00000, v[15:0]};
      default: ext = sg ? {v[31], v} : {1'b0, v};
    endcase
  endfunction

  // Value cut to the given size, upper bits cleared
  function automatic logic [31:0] trunc(input logic [31:0] v, input logic [1:0] sz);
    case (sz)
      SZ_BYTE: trunc = {24'h000000, v[7:0]};
      SZ_HALF: trunc = {16'h0000, v[15:0]};
      default: trunc = v;
    endcase
  endfunction

  function automatic logic msb_of(input logic [31:0] v, input logic [1:0] sz);
    case (sz)
      SZ_BYTE: msb_of = v[7];
      SZ_HALF: msb_of = v[15];
      default: msb_of = v[31];
    endcase
  endfunction

  // Default typing: bytes are unsigned, halfwords and words signed
  function automatic logic def_sg(input logic [1:0] sz);
    def_sg = (sz != SZ_BYTE);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        m[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    merge = m;
  endfunction

  function automatic logic [31:0] mag(input logic [32:0] v);
    mag = v[32] ? 32'(-v) : v[31:0];
  endfunction

  always_comb begin
    addr         = {avs_address_i[5:2], 2'b00};
    is_rem       = 1'b0;
    is_copy      = 1'b0;
    is_copy_word = 1'b0;
    opsz         = SZ_WORD;
    case (r.opcode)
      OPC_REM3_BYTE: begin // RULE_01
        is_rem = 1'b1;
        opsz   = SZ_BYTE;
      end
      OPC_REM3_HALF: begin // RULE_01
        is_rem = 1'b1;
        opsz   = SZ_HALF;
      end
      OPC_REM3_WORD: begin // RULE_01
        is_rem = 1'b1;
        opsz   = SZ_WORD;
      end
      OPC_COPY_BYTE: begin // RULE_07
        is_copy = 1'b1;
        opsz    = SZ_BYTE;
      end
      OPC_COPY_HALF: begin // RULE_07
        is_copy = 1'b1;
        opsz    = SZ_HALF;
      end
      OPC_COPY_WORD: begin // RULE_07
        is_copy      = 1'b1;
        is_copy_word = 1'b1;
        opsz         = SZ_WORD;
      end
      default: begin
        opsz = SZ_WORD;
      end
    endcase
    opc_ok = is_rem | is_copy;
    // Source type picks the extension, else the opcode size rules
    if (r.src_type[1:0] != SZ_NONE) begin // RULE_09
      ssz = r.src_type[1:0];
      ssg = r.src_type[TYPE_SIGN_BIT];
    end else begin
      ssz = opsz;
      ssg = def_sg(opsz);
    end
    if (r.dst_type[1:0] != SZ_NONE) begin // RULE_09
      cur_dsz = r.dst_type[1:0];
      cur_dsg = r.dst_type[TYPE_SIGN_BIT];
    end else begin
      cur_dsz = opsz;
      cur_dsg = def_sg(opsz);
    end
    src_v = ext(r.dividend_operand, ssz, ssg); // RULE_10
    a_v   = ext(r.dividend_operand, ssz, ssg);
    b_v   = ext(r.divisor_operand, ssz, ssg);
    // Remainder takes the dividend's sign
    rem_v = r.neg ? 33'(-{1'b0, div_bus.rem}) : {1'b0, div_bus.rem}; // RULE_12
    if (r.st == RME_WAIT) begin
      cv  = rem_v;
      fsz = r.dsz;
      fsg = r.dsg;
    end else begin
      cv  = src_v;
      fsz = cur_dsz;
      fsg = cur_dsg;
    end
    fin_res = trunc(cv[31:0], fsz);
    fin_fit = (ext(fin_res, fsz, fsg) == cv);
    fin_n   = msb_of(fin_res, fsz);
    fin_z   = (fin_res == 32'h00000000);
  end

  always_comb begin
    case (addr)
      REG_CTRL:     rd_mux = {30'h00000000, r.done, r.st != RME_IDLE};
      REG_OPCODE:   rd_mux = {24'h000000, r.opcode};
      REG_SRC_TYPE: rd_mux = {29'h00000000, r.src_type};
      REG_DST_TYPE: rd_mux = {29'h00000000, r.dst_type};
      REG_MODE:     rd_mux = {29'h00000000, r.mode};
      REG_DIVISOR:  rd_mux = r.divisor_operand;
      REG_DIVIDEND: rd_mux = r.dividend_operand;
      REG_RESULT:   rd_mux = r.result;
      REG_FLAGS:    rd_mux = {28'h0000000, r.flags};
      REG_EXCEPT:   rd_mux = {28'h0000000, r.exc};
      default:      rd_mux = 32'h00000000;
    endcase
  end

  always_comb begin
    next_r           = r;
    next_r.ack       = 1'b0;
    next_r.div_start = 1'b0;
    req              = avs_read_i | avs_write_i;
    // One wait cycle per access; read data is registered
    if (req && !r.ack) begin
      next_r.ack = 1'b1;
      if (avs_read_i) begin
        next_r.rdata = rd_mux;
      end
    end
    wr_now = avs_write_i && r.ack;
    start  = wr_now && (addr == REG_CTRL) && avs_byteenable_i[0]
             && avs_writedata_i[CTRL_START_BIT] && (r.st == RME_IDLE);
    if (wr_now) begin
      case (addr)
        REG_OPCODE: begin
          next_r.opcode = 8'(merge({24'h000000, r.opcode}, avs_writedata_i,
                                   avs_byteenable_i));
        end
        REG_SRC_TYPE: begin
          if (avs_byteenable_i[0]) begin
            next_r.src_type = avs_writedata_i[2:0];
          end
        end
        REG_DST_TYPE: begin
          if (avs_byteenable_i[0]) begin
            next_r.dst_type = avs_writedata_i[2:0];
          end
        end
        REG_MODE: begin
          if (avs_byteenable_i[0]) begin
            next_r.mode = avs_writedata_i[2:0];
          end
        end
        REG_DIVISOR: begin
          next_r.divisor_operand = merge(r.divisor_operand, avs_writedata_i,
                                         avs_byteenable_i);
        end
        REG_DIVIDEND: begin
          next_r.dividend_operand = merge(r.dividend_operand, avs_writedata_i,
                                          avs_byteenable_i);
        end
        default: begin
          next_r.ack = 1'b0;
        end
      endcase
    end
    case (r.st)
      RME_IDLE: begin
        if (start) begin
          next_r.done = 1'b0;
          next_r.exc  = RST_EXC;
          if (!opc_ok) begin
            next_r.exc[EXC_OPC_BIT] = 1'b1;
            next_r.done             = 1'b1;
          end else if (r.mode[MODE_LIT_BIT]) begin
            next_r.exc[EXC_ILL_BIT] = 1'b1; // RULE_06
            next_r.done             = 1'b1;
          end else if (is_copy) begin
            next_r.result = fin_res; // RULE_07
            if (!(is_copy_word && (r.mode[MODE_PSWS_BIT] || r.mode[MODE_PSWD_BIT]))) begin
              next_r.flags = {fin_n, fin_z, 1'b0, !fin_fit}; // RULE_08 RULE_11
            end
            next_r.done = 1'b1;
          end else if (b_v == 33'h000000000) begin
            // Divisor zero: no result, flags kept
            next_r.exc[EXC_ZDIV_BIT] = 1'b1; // RULE_04
            next_r.done              = 1'b1;
          end else begin
            next_r.mag_a     = mag(a_v); // RULE_02
            next_r.mag_b     = mag(b_v);
            next_r.neg       = a_v[32];
            next_r.dsz       = cur_dsz;
            next_r.dsg       = cur_dsg;
            next_r.div_start = 1'b1;
            next_r.st        = RME_WAIT;
          end
        end
      end
      RME_WAIT: begin
        if (div_bus.done) begin
          next_r.result = fin_res; // RULE_02
          // N follows the sign of the full remainder, not the bit left after cutting
          next_r.flags  = {cv[32], fin_z, 1'b0, !fin_fit}; // RULE_03
          next_r.exc[EXC_OVF_BIT] = !fin_fit; // RULE_05
          next_r.st = RME_FIN;
        end
      end
      RME_FIN: begin
        // Status becomes visible one cycle after the result
        next_r.done = 1'b1;
        next_r.st   = RME_IDLE;
      end
      default: begin
        next_r.st = RME_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      r                  <= '0;
      r.st               <= RME_IDLE;
      r.opcode           <= RST_OPCODE;
      r.src_type         <= RST_TYPE;
      r.dst_type         <= RST_TYPE;
      r.mode             <= RST_MODE;
      r.divisor_operand  <= RST_WORD;
      r.dividend_operand <= RST_WORD;
      r.result           <= RST_WORD;
      r.flags            <= RST_FLAGS;
      r.exc              <= RST_EXC;
    end else if (ce_i) begin
      r <= next_r;
    end
  end

  assign div_bus.start    = r.div_start;
  assign div_bus.dividend = r.mag_a;
  assign div_bus.divisor  = r.mag_b;

  rme_div u_div (
    .mclk_i  (mclk_i),
    .rst_b_i (rst_b_i),
    .ce_i    (ce_i),
    .div     (div_bus.unit)
  );

  assign avs_readdata_o    = r.rdata;
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~r.ack;
  assign busy_o            = (r.st != RME_IDLE);
  assign done_o            = r.done;

endmodule // rme_exec
`default_nettype wire

// ===== rme_pkg.sv
`default_nettype none
package rme_pkg;

  // Opcodes of the remainder group
  localparam logic [7:0] OPC_REM3_BYTE = 8'hE7;
  localparam logic [7:0] OPC_REM3_HALF = 8'hE6;
  localparam logic [7:0] OPC_REM3_WORD = 8'hE4;
  // Opcodes of the copy group
  localparam logic [7:0] OPC_COPY_BYTE = 8'h87;
  localparam logic [7:0] OPC_COPY_HALF = 8'h86;
  localparam logic [7:0] OPC_COPY_WORD = 8'h84;

  // Operand size codes; zero in a type register means no expanded type
  localparam logic [1:0] SZ_NONE = 2'h0;
  localparam logic [1:0] SZ_BYTE = 2'h1;
  localparam logic [1:0] SZ_HALF = 2'h2;
  localparam logic [1:0] SZ_WORD = 2'h3;

  // Register byte offsets
  localparam logic [5:0] REG_CTRL     = 6'h00;
  localparam logic [5:0] REG_OPCODE   = 6'h04;
  localparam logic [5:0] REG_SRC_TYPE = 6'h08;
  localparam logic [5:0] REG_DST_TYPE = 6'h0C;
  localparam logic [5:0] REG_MODE     = 6'h10;
  localparam logic [5:0] REG_DIVISOR  = 6'h14;
  localparam logic [5:0] REG_DIVIDEND = 6'h18;
  localparam logic [5:0] REG_RESULT   = 6'h1C;
  localparam logic [5:0] REG_FLAGS    = 6'h20;
  localparam logic [5:0] REG_EXCEPT   = 6'h24;

  // Field positions
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_BUSY_BIT  = 0;
  localparam int CTRL_DONE_BIT  = 1;
  localparam int TYPE_SIGN_BIT  = 2;
  localparam int MODE_LIT_BIT   = 0;
  localparam int MODE_PSWS_BIT  = 1;
  localparam int MODE_PSWD_BIT  = 2;
  localparam int FLAG_N_BIT     = 3;
  localparam int FLAG_Z_BIT     = 2;
  localparam int FLAG_C_BIT     = 1;
  localparam int FLAG_V_BIT     = 0;
  localparam int EXC_ILL_BIT    = 0;
  localparam int EXC_ZDIV_BIT   = 1;
  localparam int EXC_OVF_BIT    = 2;
  localparam int EXC_OPC_BIT    = 3;

  // Reset values
  localparam logic [7:0]  RST_OPCODE = 8'h00;
  localparam logic [2:0]  RST_TYPE   = 3'h0;
  localparam logic [2:0]  RST_MODE   = 3'h0;
  localparam logic [31:0] RST_WORD   = 32'h00000000;
  localparam logic [3:0]  RST_FLAGS  = 4'h0;
  localparam logic [3:0]  RST_EXC    = 4'h0;

  // Divider iteration count, one quotient bit per cycle
  localparam logic [5:0] DIV_STEPS = 6'h20;

  typedef enum logic [1:0] {
    RME_IDLE = 2'b00,
    RME_WAIT = 2'b01,
    RME_FIN  = 2'b11
  } rme_state_t;

endpackage
`default_nettype wire

// ===== rme_div_if.sv
`default_nettype none
interface rme_div_if;
  logic        start;
  logic [31:0] dividend;
  logic [31:0] divisor;
  logic        done;
  logic [31:0] rem;

  modport ctl (
    output start,
    output dividend,
    output divisor,
    input  done,
    input  rem
  );

  modport unit (
    input  start,
    input  dividend,
    input  divisor,
    output done,
    output rem
  );
endinterface
`default_nettype wire

// ===== rme_div.sv
`default_nettype none
module rme_div (
  // Clock and reset
  input  wire logic mclk_i,
  input  wire logic rst_b_i,
  input  wire logic ce_i,
  // Operand and answer
  rme_div_if.unit   div
);
  import rme_pkg::*;

  typedef struct packed {
    logic        busy;
    logic        done;
    logic [5:0]  cnt;
    logic [31:0] rem;
    logic [31:0] quo;
    logic [31:0] den;
  } rme_div_st_t;

  rme_div_st_t r;
  rme_div_st_t next_r;
  logic [32:0] part;
  logic        ge;

  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    part = {r.rem, r.quo[31]};
    ge = (part >= {1'b0, r.den});
    if (div.start) begin
      next_r.busy = 1'b1;
      next_r.cnt  = DIV_STEPS;
      next_r.rem  = RST_WORD;
      next_r.quo  = div.dividend;
      next_r.den  = div.divisor;
    end else if (r.busy) begin
      // Restoring step: magnitudes only, sign is applied by the caller
      next_r.rem = ge ? 32'(part - {1'b0, r.den}) : part[31:0];
      next_r.quo = {r.quo[30:0], ge};
      next_r.cnt = 6'(r.cnt - 6'h01);
      if (r.cnt == 6'h01) begin
        next_r.busy = 1'b0;
        next_r.done = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      r <= '0;
    end else if (ce_i) begin
      r <= next_r;
    end
  end

  assign div.done = r.done;
  assign div.rem  = r.rem;

endmodule // rme_div
`default_nettype wire

// ===== rme_exec_checker.sv
`default_nettype none
module rme_exec_checker
  import rme_pkg::*;
(
  // Clock and reset
  input wire logic        mclk_i,
  input wire logic        rst_b_i,
  input wire logic        ce_i,
  // Bus
  input wire logic [5:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0]  avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  // Execution
  input wire logic        busy_o,
  input wire logic        done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  logic go;
  logic rd_flags;
  assign go = avs_write_i && !avs_waitrequest_o && avs_address_i == REG_CTRL && avs_writedata_i[0];
  assign rd_flags = avs_read_i && !avs_waitrequest_o && avs_address_i == REG_FLAGS;
  sequence s_ack;
    avs_waitrequest_o ##1 !avs_waitrequest_o;
  endsequence
  // Run length counted on enabled cycles only, so a frozen clock enable does not trip it
  localparam int RUN_LEN = int'(DIV_STEPS) + 3;
  logic [6:0] run_cnt;
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      run_cnt <= 7'h00;
    end else if (!busy_o) begin
      run_cnt <= 7'h00;
    end else if (ce_i) begin
      run_cnt <= 7'(run_cnt + 7'h01);
    end
  end
  sequence s_run;
    done_o && run_cnt == 7'(RUN_LEN);
  endsequence
  a_wait_only: assert property (avs_waitrequest_o |-> (avs_read_i || avs_write_i))
    else $error("waitrequest without request");
  a_ack_late: assert property ($rose(avs_read_i || avs_write_i) && ce_i |-> s_ack)
    else $error("bus answer not after one cycle");
  a_start_resp: assert property (go && !busy_o |=> busy_o || done_o)
    else $error("start not answered");
  a_rem_time: assert property ($fell(busy_o) |-> s_run)
    else $error("remainder run length wrong");
  a_run_bound: assert property (busy_o |-> run_cnt < 7'(RUN_LEN))
    else $error("remainder run too long");
  a_busy_cause: assert property ($rose(busy_o) |-> $past(go))
    else $error("busy without start");
  a_done_sticky: assert property (done_o && !go |=> done_o)
    else $error("done dropped without start");
  a_busy_done: assert property (busy_o |-> !done_o)
    else $error("busy and done together");
  a_carry_zero: assert property (rd_flags |-> avs_readdata_o[FLAG_C_BIT] == 1'b0)
    else $error("carry flag set");
  a_flag_width: assert property (rd_flags |-> avs_readdata_o[31:4] == 28'h0000000)
    else $error("flag register upper bits set");
endmodule // rme_exec_checker
`default_nettype wire

// ===== rme_host.sv
`default_nettype none
module rme_host (
  // Clock
  input  wire logic        mclk_i,
  // Slave answer
  input  wire logic        wait_i,
  input  wire logic [31:0] rdata_i,
  // Request
  output logic [5:0]       addr_o,
  output logic             read_o,
  output logic             write_o,
  output logic [31:0]      wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    addr_o = 6'h3F;
    read_o = 1'b0;
    write_o = 1'b0;
    wdata_o = 32'h00000000;
  end
  // Held until waitrequest low at an edge; released lines show inverted junk
  task automatic xfer(input logic rw, input logic [5:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge mclk_i);
    addr_o <= a;
    read_o <= !rw;
    write_o <= rw;
    wdata_o <= d;
    do @(posedge mclk_i); while (wait_i !== 1'b0);
    q = rdata_i;
    read_o <= 1'b0;
    write_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
endmodule // rme_host
`default_nettype wire

// ===== rme_exec_test.sv
`default_nettype none
module rme_exec_test;
  timeunit 1ns;
  timeprecision 1ps;
  import rme_pkg::*;
  logic mclk_i, rst_b_i, ce_i, avs_read_i, avs_write_i, avs_waitrequest_o, busy_o, done_o;
  logic [5:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, q, p_res;
  logic [3:0] p_fl;
  logic frz = 1'b0;
  logic [7:0] ops [6] = '{OPC_REM3_BYTE, OPC_REM3_HALF, OPC_REM3_WORD,
                          OPC_COPY_BYTE, OPC_COPY_HALF, OPC_COPY_WORD};
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;
  rme_exec rme_exec_i (.mclk_i, .rst_b_i, .ce_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i(4'hF), .avs_readdata_o, .avs_waitrequest_o,
    .busy_o, .done_o);
  rme_host rme_host_i (.mclk_i, .wait_i(avs_waitrequest_o), .rdata_i(avs_readdata_o),
    .addr_o(avs_address_i), .read_o(avs_read_i), .write_o(avs_write_i),
    .wdata_o(avs_writedata_i));
  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Generous ceiling; a normal run needs about an eighth of it
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      test_done();
    end
  end
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] x;
    rme_host_i.xfer(1'b1, a, d, x);
  endtask
  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    rme_host_i.xfer(1'b0, a, 32'h00000000, d);
  endtask
  function automatic longint ext(input logic [31:0] v, input logic [1:0] sz, input logic sg);
    if (sz == SZ_BYTE) return sg ? longint'($signed(v[7:0])) : longint'(v[7:0]);
    if (sz == SZ_HALF) return sg ? longint'($signed(v[15:0])) : longint'(v[15:0]);
    return sg ? longint'($signed(v)) : longint'(v);
  endfunction
  task automatic run(input logic [7:0] op, input logic [2:0] st, input logic [2:0] dt,
                     input logic [2:0] md, input logic [31:0] a, input logic [31:0] b);
    logic [31:0] er, r;
    logic [3:0] ef, ex;
    logic [1:0] isz, ssz, dsz;
    logic ssg, dsg, rem, known, zd, v;
    longint x, y, f;
    int n;
    known = op inside {ops};
    rem = op[7:4] == 4'hE;
    isz = op[1:0] == 2'b11 ? SZ_BYTE : (op[1] ? SZ_HALF : SZ_WORD);
    ssz = st[1:0] != SZ_NONE ? st[1:0] : isz;
    ssg = st[1:0] != SZ_NONE ? st[2] : ssz != SZ_BYTE;
    dsz = dt[1:0] != SZ_NONE ? dt[1:0] : isz;
    dsg = dt[1:0] != SZ_NONE ? dt[2] : dsz != SZ_BYTE;
    x = ext(b, ssz, ssg);
    y = ext(a, ssz, ssg);
    zd = rem && y == 0;
    f = rem ? (zd ? 0 : x % y) : x;
    er = 32'(f) & (dsz == SZ_BYTE ? 32'hFF : (dsz == SZ_HALF ? 32'hFFFF : 32'hFFFFFFFF));
    v = ext(er, dsz, dsg) != f;
    ef = {rem ? f < 0 : ext(er, dsz, 1'b1) < 0, er == 0, 1'b0, v};
    ex = !known ? 4'h8 : (md[0] ? 4'h1 : (zd ? 4'h2 : {1'b0, rem && v, 2'b00}));
    if (md[0] || zd) begin
      er = p_res;
      ef = p_fl;
    end
    if (op == OPC_COPY_WORD && md[2:1] != 2'b00) ef = p_fl;
    wr(REG_OPCODE, {24'h000000, op});
    wr(REG_SRC_TYPE, {29'h0, st});
    wr(REG_DST_TYPE, {29'h0, dt});
    wr(REG_MODE, {29'h0, md});
    wr(REG_DIVISOR, a);
    wr(REG_DIVIDEND, b);
    wr(REG_CTRL, 32'h1);
    wr(REG_CTRL, 32'h1);
    if (frz) begin
      ce_i <= 1'b0;
      repeat (60) @(posedge mclk_i);
      check(32'({busy_o, done_o}), 32'h2);
      ce_i <= 1'b1;
    end
    n = 0;
    do begin
      rd(REG_CTRL, r);
      n++;
    end while (r[CTRL_DONE_BIT] !== 1'b1 && n < 100);
    check(r, 32'h2);
    rd(REG_EXCEPT, r);
    check(r & (!known ? 32'h8 : (rem ? 32'hF : 32'hB)), 32'(ex));
    if (known) begin
      rd(REG_RESULT, r);
      check(r, er);
      rd(REG_FLAGS, r);
      check(r, 32'(ef));
      p_res = er;
      p_fl = ef;
    end
  endtask
  initial begin
    rst_b_i = 1'b0;
    ce_i = 1'b1;
    p_res = 32'h00000000;
    p_fl = 4'h0;
    void'($urandom(10336));
    repeat (3) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      rd(6'(i * 4), q);
      check(q, 32'h00000000);
    end
    wr(REG_RESULT, 32'hFFFFFFFF);
    rd(REG_RESULT, q);
    check(q, 32'h00000000);
    $display("test reset values done");
    foreach (ops[i]) begin
      run(ops[i], 3'h0, 3'h0, 3'h0, 32'h3, 32'hFFFFFFF9);
      run(ops[i], 3'h0, 3'h0, 3'h0, 32'h5, 32'h80);
      run(ops[i], 3'h0, 3'h0, 3'h0, 32'h0, 32'h9);
      run(ops[i], 3'h0, 3'h0, 3'h1, 32'h3, 32'h9);
    end
    $display("test opcode table done");
    run(OPC_COPY_BYTE, 3'h5, 3'h6, 3'h0, 32'h0, 32'h80);
    run(OPC_COPY_BYTE, 3'h5, 3'h7, 3'h0, 32'h0, 32'h80);
    run(OPC_COPY_BYTE, 3'h1, 3'h7, 3'h0, 32'h0, 32'h80);
    run(OPC_COPY_HALF, 3'h2, 3'h7, 3'h0, 32'h0, 32'h8001);
    run(OPC_COPY_HALF, 3'h0, 3'h5, 3'h0, 32'h0, 32'h1234);
    run(OPC_COPY_WORD, 3'h0, 3'h6, 3'h0, 32'h0, 32'h12345678);
    run(OPC_REM3_WORD, 3'h7, 3'h5, 3'h0, 32'h1000, 32'h1FFF);
    $display("test conversions done");
    run(OPC_REM3_WORD, 3'h0, 3'h0, 3'h0, 32'h3, 32'hFFFFFFF9);
    run(OPC_COPY_WORD, 3'h0, 3'h0, 3'h2, 32'h0, 32'h0);
    run(OPC_COPY_WORD, 3'h0, 3'h0, 3'h4, 32'h0, 32'h5);
    run(8'h55, 3'h0, 3'h0, 3'h0, 32'h1, 32'h1);
    $display("test status word and bad opcode done");
    frz = 1'b1;
    run(OPC_REM3_HALF, 3'h0, 3'h0, 3'h0, 32'h7, 32'hFFFF8003);
    frz = 1'b0;
    $display("test clock enable hold done");
    repeat (60) begin
      run(ops[$urandom % 6], $urandom % 2 ? 3'h0 : {1'($urandom), 2'($urandom % 3 + 1)},
          $urandom % 2 ? 3'h0 : {1'($urandom), 2'($urandom % 3 + 1)},
          3'($urandom) & ($urandom % 6 == 0 ? 3'h7 : 3'h6),
          $urandom % 4 == 0 ? $urandom % 9 : $urandom, $urandom);
    end
    $display("test random done");
    test_done();
  end
endmodule // rme_exec_test
bind rme_exec rme_exec_checker rme_exec_checker_i (.mclk_i, .rst_b_i, .ce_i, .avs_address_i,
  .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
  .avs_waitrequest_o, .busy_o, .done_o);
`default_nettype wire
